// ===== common/lesr_pkg.sv
// shared constants and carrier types for the led engine status and output registers
package lesr_pkg;
  // ********************************************************
  // register offsets
  // ********************************************************
  localparam logic [7:0] LESR_ADDR_STATUS = 8'h3a;
  localparam logic [7:0] LESR_ADDR_OUTCTL = 8'h3b;
  localparam logic [7:0] LESR_ADDR_VAR = 8'h3c;
  localparam logic [7:0] LESR_ADDR_SRST = 8'h3d;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int LESR_BIT_ENG1 = 2;
  localparam int LESR_BIT_ENG2 = 1;
  localparam int LESR_BIT_ENG3 = 0;
  localparam int LESR_BIT_EXTCLK = 3;
  localparam int LESR_BIT_PINSEL = 2;
  localparam int LESR_BIT_GPO = 1;
  localparam int LESR_BIT_PINLVL = 0;
  localparam int LESR_NUM_ENG = 3;

  // ********************************************************
  // reset values and fixed patterns
  // ********************************************************
  localparam logic [2:0] LESR_FLAGS_RST = 3'h0;
  localparam logic [2:0] LESR_OUTCTL_RST = 3'h0;
  localparam logic [7:0] LESR_VAR_RST = 8'h00;
  localparam logic [7:0] LESR_SRST_KEY = 8'hff;
  localparam logic [7:0] LESR_SRST_READ = 8'h03;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int LESR_CLK_PERIOD_PS = 8000;
  localparam int LESR_CLK_DET_WINDOW_NS = 1000;
  localparam int LESR_CLK_DET_CYCLES =
    (LESR_CLK_DET_WINDOW_NS * 1000 + LESR_CLK_PERIOD_PS - 1) / LESR_CLK_PERIOD_PS;

  // ********************************************************
  // carrier types
  // ********************************************************
  typedef struct packed
  {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lesr_req_s;

  typedef struct packed
  {
    logic out;
    logic oe;
  } lesr_pin_s;
endpackage

// ===== design/lesr_clk_detect.sv
// activity detector for the external clock pin
`timescale 1ns/1ps
`default_nettype none
module lesr_clk_detect
  import lesr_pkg::*;
#(
  parameter int TIMEOUT = LESR_CLK_DET_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sw_clear,
  input wire logic detect_en,
  input wire logic ext_clk_pin,
  output logic clock_seen
);
  localparam int CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(TIMEOUT);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic [CW-1:0] cnt_q;
  logic seen_q;
  logic clr;
  logic edge_seen;

  assign clr = !rst_n || sw_clear;
  assign edge_seen = sync2_q ^ prev_q;
  assign clock_seen = seen_q;

  // two-stage synchroniser, then edge history
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_q <= ext_clk_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // flag only moves while detection is enabled, or when reset or sw_clear clears it
  always_ff @(posedge clk_sys)
  begin
    if (clr)
    begin
      cnt_q <= '0;
      seen_q <= 1'b0;
    end
    else if (clk_en && detect_en)
    begin
      if (edge_seen)
      begin
        cnt_q <= CNT_LOAD;
        seen_q <= 1'b1;
      end
      else if (cnt_q != '0)
        cnt_q <= cnt_q - 1'b1;
      else
        seen_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== design/lesr_regs.sv
// status flags, output pin control, program variable and soft reset registers
`timescale 1ns/1ps
`default_nettype none
module lesr_regs
  import lesr_pkg::*;
#(
  parameter int CLK_DET_CYCLES = LESR_CLK_DET_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire lesr_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [LESR_NUM_ENG-1:0] engine_irq_evt,
  input wire logic clock_detect_enable,
  input wire logic ext_clk_pin,
  output logic general_output_pin,
  output lesr_pin_s irq_pin,
  output logic [7:0] program_variable,
  output logic soft_reset_pulse
);
  // ********************************************************
  // declarations
  // ********************************************************
  logic [LESR_NUM_ENG-1:0] flags_q;
  logic [LESR_NUM_ENG-1:0] flags_d;
  logic [2:0] outctl_q;
  logic [7:0] var_q;
  logic srst_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic local_rst;
  logic rd_fire;
  logic wr_fire;
  logic sel_status;
  logic sel_outctl;
  logic sel_var;
  logic sel_srst;
  logic status_rd;
  logic srst_hit;
  logic external_clock_seen;
  logic engine_one_irq_flag;
  logic engine_two_irq_flag;
  logic engine_three_irq_flag;
  logic irq_pin_function_sel;
  logic general_output_level;
  logic irq_pin_output_level;
  logic [7:0] status_word;
  logic [7:0] outctl_word;
  logic irq_drive_level;
  logic irq_drive_en;

  // ********************************************************
  // decode
  // ********************************************************
  assign local_rst = !rst_n || srst_q;
  assign rd_fire = clk_en && reg_req.rd;
  assign wr_fire = clk_en && reg_req.wr;
  assign sel_status = reg_req.addr == LESR_ADDR_STATUS;
  assign sel_outctl = reg_req.addr == LESR_ADDR_OUTCTL;
  assign sel_var = reg_req.addr == LESR_ADDR_VAR;
  assign sel_srst = reg_req.addr == LESR_ADDR_SRST;
  assign status_rd = rd_fire && sel_status;
  assign srst_hit = wr_fire && sel_srst && (reg_req.wdata == LESR_SRST_KEY);

  assign engine_one_irq_flag = flags_q[LESR_BIT_ENG1];
  assign engine_two_irq_flag = flags_q[LESR_BIT_ENG2];
  assign engine_three_irq_flag = flags_q[LESR_BIT_ENG3];
  assign irq_pin_function_sel = outctl_q[LESR_BIT_PINSEL];
  assign general_output_level = outctl_q[LESR_BIT_GPO];
  assign irq_pin_output_level = outctl_q[LESR_BIT_PINLVL];

  // ********************************************************
  // external clock detection
  // ********************************************************
  lesr_clk_detect #(
    .TIMEOUT(CLK_DET_CYCLES)
  ) u_clk_detect (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .sw_clear(srst_q),
    .detect_en(clock_detect_enable),
    .ext_clk_pin(ext_clk_pin),
    .clock_seen(external_clock_seen)
  );

  // ********************************************************
  // engine flags
  // ********************************************************
  // a set arriving with the clearing read survives it
  genvar gi;
  generate
    for (gi = 0; gi < LESR_NUM_ENG; gi++)
    begin : g_flag
      assign flags_d[gi] = engine_irq_evt[gi] || (flags_q[gi] && !status_rd);
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (local_rst)
      flags_q <= LESR_FLAGS_RST;
    else if (clk_en)
      flags_q <= flags_d;
  end

  // ********************************************************
  // writable registers
  // ********************************************************
  always_ff @(posedge clk_sys)
  begin
    if (local_rst)
    begin
      outctl_q <= LESR_OUTCTL_RST;
      var_q <= LESR_VAR_RST;
    end
    else if (wr_fire)
    begin
      if (sel_outctl)
        outctl_q <= reg_req.wdata[2:0];
      if (sel_var)
        var_q <= reg_req.wdata;
    end
  end

  // soft reset pulse; held one cycle, then clears the bank
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      srst_q <= 1'b0;
    else if (clk_en)
      srst_q <= srst_hit;
  end

  // ********************************************************
  // read path
  // ********************************************************
  assign status_word = {4'h0, external_clock_seen, engine_one_irq_flag, engine_two_irq_flag,
                        engine_three_irq_flag};
  assign outctl_word = {5'h00, outctl_q};
  assign rdata_d = sel_status ? status_word :
                   sel_outctl ? outctl_word :
                   sel_var ? var_q :
                   sel_srst ? LESR_SRST_READ :
                   8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (local_rst)
      rdata_q <= 8'h00;
    else if (rd_fire)
      rdata_q <= rdata_d;
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign reg_rdata = rdata_q;
  assign program_variable = var_q;
  assign soft_reset_pulse = srst_q;
  assign general_output_pin = general_output_level;
  // interrupt role: only ever pulls low; output role: push-pull at the chosen level
  assign irq_drive_level = irq_pin_function_sel ? irq_pin_output_level : 1'b0;
  assign irq_drive_en = irq_pin_function_sel ? 1'b1 : (|flags_q);
  assign irq_pin = '{out: irq_drive_level, oe: irq_drive_en};

  // ********************************************************
  // checks
  // ********************************************************
  sequence srst_write_s;
    srst_hit && !srst_q;
  endsequence

  sequence srst_done_s;
    ##1 srst_q ##1 (flags_q == LESR_FLAGS_RST && var_q == LESR_VAR_RST &&
                    outctl_q == LESR_OUTCTL_RST);
  endsequence

  sequence status_read_s;
    status_rd && !srst_q && engine_irq_evt == '0;
  endsequence

  flag_set_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !srst_q && engine_irq_evt != '0) |=> ((flags_q & $past(engine_irq_evt))
      == $past(engine_irq_evt)))
    else $error("engine event did not set its flag");

  read_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    status_read_s |=> (flags_q == '0) && (reg_rdata[2:0] == $past(flags_q)))
    else $error("status read did not return and clear flags");

  extclk_read_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (status_rd && !srst_q) |=> reg_rdata[LESR_BIT_EXTCLK] == $past(external_clock_seen))
    else $error("external clock flag misread");

  detect_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!clock_detect_enable && !srst_q) |=> $stable(external_clock_seen))
    else $error("clock flag moved while detection disabled");

  irq_drain_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !irq_pin_function_sel |-> (irq_pin.out == 1'b0) && (irq_pin.oe == (|flags_q)))
    else $error("interrupt pin not open-drain active low");

  irq_release_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (status_read_s and (!irq_pin_function_sel && !(wr_fire && sel_outctl))) |=> !irq_pin.oe)
    else $error("interrupt pin not released after clearing read");

  pin_role_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_fire && sel_outctl && !srst_q && reg_req.wdata[LESR_BIT_PINSEL]) |=> irq_pin.oe)
    else $error("output role did not take the interrupt pin");

  pin_level_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_fire && sel_outctl && !srst_q && reg_req.wdata[LESR_BIT_PINSEL]) |=>
      irq_pin.out == $past(reg_req.wdata[LESR_BIT_PINLVL]))
    else $error("interrupt pin level not taken from register");

  gpo_level_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_fire && sel_outctl && !srst_q) |=>
      general_output_pin == $past(reg_req.wdata[LESR_BIT_GPO]))
    else $error("general output pin level wrong");

  var_write_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_fire && sel_var && !srst_q) |=> program_variable == $past(reg_req.wdata))
    else $error("program variable not written");

  soft_reset_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    srst_write_s |-> srst_done_s)
    else $error("soft reset did not restore defaults");

  no_reset_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_fire && sel_srst && reg_req.wdata != LESR_SRST_KEY && !srst_q) |=> !srst_q)
    else $error("soft reset from wrong pattern");

  srst_read_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (rd_fire && sel_srst && !srst_q) |=> reg_rdata == LESR_SRST_READ)
    else $error("reset register read wrong");

  sequence evt_taken_s;
    clk_en && !srst_q && engine_irq_evt != '0 && !(wr_fire && sel_outctl);
  endsequence

  set_wins_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (status_rd && !srst_q && engine_irq_evt != '0) |=>
      (flags_q == $past(engine_irq_evt)) && (reg_rdata[2:0] == $past(flags_q)))
    else $error("event lost to a clearing read");

  flag_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!status_rd && engine_irq_evt == '0 && !srst_q) |=> $stable(flags_q))
    else $error("engine flag moved without event or read");

  irq_assert_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    evt_taken_s |=> irq_pin_function_sel || (irq_pin.oe && !irq_pin.out))
    else $error("interrupt pin not pulled low after event");

  outctl_keep_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!(wr_fire && sel_outctl) && !srst_q) |=> $stable(general_output_pin) &&
      $stable(irq_pin_function_sel) && $stable(irq_pin_output_level))
    else $error("output control moved without a write");

  var_keep_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!(wr_fire && sel_var) && !srst_q) |=> $stable(program_variable))
    else $error("program variable moved without a write");

  pulse_width_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (srst_q && clk_en && !srst_hit) |=> !soft_reset_pulse)
    else $error("soft reset pulse longer than one cycle");

  rdata_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!rd_fire && !srst_q) |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  unmapped_read_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (rd_fire && !srst_q && !(sel_status || sel_outctl || sel_var || sel_srst)) |=>
      reg_rdata == 8'h00)
    else $error("unmapped offset read not zero");

  freeze_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!clk_en && !srst_q) |=> $stable(flags_q) && $stable(outctl_q) && $stable(var_q) &&
      $stable(reg_rdata) && $stable(external_clock_seen) && !srst_q)
    else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// ===== verif/lesr_host_model.sv
// host side model that issues register reads and writes
`timescale 1ns/1ps
`default_nettype none
module lesr_host_model
  import lesr_pkg::*;
(
  input wire logic clk_sys,
  output var lesr_req_s reg_req,
  input wire logic [7:0] reg_rdata
);
  initial reg_req = '0;
  // one-cycle read strobe, data taken once the answering edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
    d = reg_rdata;
  endtask
  // the reset key goes out only when the caller passes it
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
  endtask
endmodule
`default_nettype wire

// ===== verif/lesr_regs_tb.sv
// self-checking testbench for the status and output registers
`timescale 1ns/1ps
`default_nettype none
module lesr_regs_tb
  import lesr_pkg::*;
;
  localparam int DET = 4;
  logic clk_sys, rst_n, clk_en, ext_clk_pin, clock_detect_enable, ext_run;
  logic general_output_pin, soft_reset_pulse;
  logic [2:0] engine_irq_evt;
  logic [7:0] reg_rdata, program_variable, rd_v;
  lesr_req_s reg_req;
  lesr_pin_s irq_pin;
  int n_mismatch, checked;

  lesr_regs #(.CLK_DET_CYCLES(DET)) u_lesr_regs (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .engine_irq_evt(engine_irq_evt), .clock_detect_enable(clock_detect_enable),
    .ext_clk_pin(ext_clk_pin), .general_output_pin(general_output_pin),
    .irq_pin(irq_pin), .program_variable(program_variable),
    .soft_reset_pulse(soft_reset_pulse));
  lesr_host_model u_lesr_host_model (.clk_sys(clk_sys), .reg_req(reg_req),
    .reg_rdata(reg_rdata));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // external clock kept off the system clock's edges
  initial
  begin
    ext_clk_pin = 1'b0;
    #1;
    forever
    begin
      #12;
      if (ext_run)
        ext_clk_pin = ~ext_clk_pin;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_lesr_host_model.rd(a, rd_v);
    chk(rd_v, exp);
  endtask
  // packs general output, irq enable and irq level
  task automatic pinchk(input logic [2:0] exp);
    chk({5'h00, general_output_pin, irq_pin.oe, irq_pin.out}, {5'h00, exp});
  endtask
  task automatic evt(input logic [2:0] v);
    @(posedge clk_sys);
    engine_irq_evt <= v;
    @(posedge clk_sys);
    engine_irq_evt <= 3'h0;
    #1;
  endtask
  task automatic detect(input logic en, input logic run);
    @(posedge clk_sys);
    clock_detect_enable <= en;
    ext_run = run;
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic t_reset_values();
    rdchk(LESR_ADDR_OUTCTL, 8'h00);
    rdchk(LESR_ADDR_VAR, 8'h00);
    rdchk(LESR_ADDR_SRST, 8'h03);
    rdchk(8'h3e, 8'h00);
    u_lesr_host_model.wr(LESR_ADDR_STATUS, 8'hff);
    rdchk(LESR_ADDR_STATUS, 8'h00);
    pinchk(3'b000);
  endtask
  task automatic t_engine_flags();
    for (int i = 0; i < LESR_NUM_ENG; i++)
    begin
      evt(3'h1 << i);
      pinchk(3'b010);
      rdchk(LESR_ADDR_STATUS, 8'h01 << i);
      pinchk(3'b000);
      rdchk(LESR_ADDR_STATUS, 8'h00);
    end
  endtask
  task automatic t_pin_role();
    evt(3'b100);
    u_lesr_host_model.wr(LESR_ADDR_OUTCTL, 8'h05);
    pinchk(3'b011);
    u_lesr_host_model.wr(LESR_ADDR_OUTCTL, 8'h03);
    pinchk(3'b110);
    rdchk(LESR_ADDR_STATUS, 8'h04);
    pinchk(3'b100);
    rdchk(LESR_ADDR_OUTCTL, 8'h03);
    u_lesr_host_model.wr(LESR_ADDR_OUTCTL, 8'h04);
    pinchk(3'b010);
  endtask
  task automatic t_ext_clock();
    detect(1'b0, 1'b1);
    rdchk(LESR_ADDR_STATUS, 8'h00);
    detect(1'b1, 1'b1);
    rdchk(LESR_ADDR_STATUS, 8'h08);
    detect(1'b0, 1'b0);
    rdchk(LESR_ADDR_STATUS, 8'h08);
    detect(1'b1, 1'b0);
    rdchk(LESR_ADDR_STATUS, 8'h00);
  endtask
  task automatic t_soft_reset();
    u_lesr_host_model.wr(LESR_ADDR_VAR, 8'ha5);
    chk(program_variable, 8'ha5);
    u_lesr_host_model.wr(LESR_ADDR_SRST, 8'h55);
    chk({7'h00, soft_reset_pulse}, 8'h00);
    rdchk(LESR_ADDR_VAR, 8'ha5);
    rdchk(LESR_ADDR_SRST, 8'h03);
    evt(3'b001);
    u_lesr_host_model.wr(LESR_ADDR_SRST, 8'hff);
    chk({7'h00, soft_reset_pulse}, 8'h01);
    @(posedge clk_sys);
    #1;
    rdchk(LESR_ADDR_VAR, 8'h00);
    pinchk(3'b000);
    rdchk(LESR_ADDR_STATUS, 8'h00);
    rdchk(LESR_ADDR_OUTCTL, 8'h00);
  endtask

  task automatic t_clock_enable();
    u_lesr_host_model.wr(LESR_ADDR_VAR, 8'h3c);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    u_lesr_host_model.wr(LESR_ADDR_VAR, 8'hc3);
    evt(3'b010);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    chk(program_variable, 8'h3c);
    rdchk(LESR_ADDR_STATUS, 8'h00);
  endtask
  // event and clearing read on the same edge: the event must survive
  task automatic t_set_wins();
    fork
      u_lesr_host_model.rd(LESR_ADDR_STATUS, rd_v);
      evt(3'b010);
    join
    chk(rd_v, 8'h00);
    pinchk(3'b010);
    rdchk(LESR_ADDR_STATUS, 8'h02);
    pinchk(3'b000);
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    engine_irq_evt = 3'h0;
    clock_detect_enable = 1'b0;
    ext_run = 1'b0;
    n_mismatch = 0;
    checked = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset_values();
    t_engine_flags();
    t_pin_role();
    t_ext_clock();
    t_soft_reset();
    t_clock_enable();
    t_set_wins();
    conclude();
  end
  initial
  begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
